// ---- dacwc_checker_assertions.sv ----
// Port-level checks for the converter write and control block.
`timescale 1ns/10ps
module dacwc_checker (
    input wire clk,
    input wire srst,
    input wire conversion_active,
    input wire [95:0] dac_code,
    input wire [95:0] input_code_ff,
    input wire [7:0] analog_output_select_bits_ff,
    input wire [23:0] pin_function_ff,
    input wire [1:0] dac_load_mode_ff,
    input wire adc_buffer_enable_ff,
    input wire adc_buffer_precharge_ff,
    input wire adc_buffer_power_ff,
    input wire pin_config_locked_ff,
    input wire broadcast_write_ff,
    input wire command_done_ff
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // The first edge after reset still sees old codes, hence the past test.
    property p_done;
        command_done_ff |=> !command_done_ff;
    endproperty
    a_done: assert property (p_done)
        else $error("done pulse too long");
    property p_dac_moves;
        $changed(dac_code) && !$past(srst) |-> command_done_ff;
    endproperty
    a_dac_moves: assert property (p_dac_moves)
        else $error("dac code moved without a command");
    property p_all_copy;
        $changed(dac_code) && dac_load_mode_ff == 2'h1 && !$past(srst)
            |-> dac_code == input_code_ff;
    endproperty
    a_all_copy: assert property (p_all_copy)
        else $error("held mode dac change is not a full copy");
    property p_lock;
        pin_config_locked_ff |=> $stable(analog_output_select_bits_ff)
            && $stable(pin_function_ff);
    endproperty
    a_lock: assert property (p_lock)
        else $error("pin config changed while locked");
    property p_buf_on;
        adc_buffer_enable_ff && !adc_buffer_precharge_ff
            |=> adc_buffer_power_ff;
    endproperty
    a_buf_on: assert property (p_buf_on)
        else $error("enabled buffer not powered");
    property p_buf_off;
        !adc_buffer_enable_ff |=> !adc_buffer_power_ff;
    endproperty
    a_buf_off: assert property (p_buf_off)
        else $error("disabled buffer powered");
    property p_prech;
        adc_buffer_enable_ff && adc_buffer_precharge_ff
            |=> adc_buffer_power_ff == $past(conversion_active);
    endproperty
    a_prech: assert property (p_prech)
        else $error("precharge power does not follow conversion");
    property p_dac_pin;
        $rose(analog_output_select_bits_ff[0])
            |-> pin_function_ff[2:1] == 2'h1;
    endproperty
    a_dac_pin: assert property (p_dac_pin)
        else $error("pin zero not a dac output");
    c_bcast: cover property (command_done_ff && broadcast_write_ff);
    c_lock: cover property (command_done_ff && pin_config_locked_ff);
    c_prech: cover property (adc_buffer_power_ff && adc_buffer_precharge_ff);
endmodule // dacwc_checker
bind dacwc_top dacwc_checker u_chk (
    .clk(clk), .srst(srst), .conversion_active(conversion_active),
    .dac_code(dac_code), .input_code_ff(input_code_ff),
    .analog_output_select_bits_ff(analog_output_select_bits_ff),
    .pin_function_ff(pin_function_ff), .dac_load_mode_ff(dac_load_mode_ff),
    .adc_buffer_enable_ff(adc_buffer_enable_ff),
    .adc_buffer_precharge_ff(adc_buffer_precharge_ff),
    .adc_buffer_power_ff(adc_buffer_power_ff),
    .pin_config_locked_ff(pin_config_locked_ff),
    .broadcast_write_ff(broadcast_write_ff), .command_done_ff(command_done_ff)
);

// ---- dacwc_defines.vh ----
// Constants shared by the converter write and control logic.
`ifndef DACWC_DEFINES_VH
`define DACWC_DEFINES_VH

// ****************************************
// Serial frame layout
// ****************************************
`define DACWC_FRAME_BITS 16
`define DACWC_FRAME_CNT_W 5
`define DACWC_FRAME_CNT_FULL 5'h10
`define DACWC_FRAME_CNT_OVER 5'h11
`define DACWC_BIT_KIND 15
`define DACWC_ADDR_HI 14
`define DACWC_ADDR_LO 11
`define DACWC_CHAN_HI 14
`define DACWC_CHAN_LO 12
`define DACWC_DATA_HI 11
`define DACWC_DATA_LO 0
`define DACWC_PINS_HI 7
`define DACWC_PINS_LO 0

// ****************************************
// Control register addresses
// ****************************************
`define DACWC_REG_LOADMODE 4'h7
`define DACWC_REG_GPCTL 4'h3
`define DACWC_REG_ADCCFG 4'h4
`define DACWC_REG_DACCFG 4'h5
`define DACWC_REG_PDCFG 4'h6
`define DACWC_REG_GPOCFG 4'h8
`define DACWC_REG_GPICFG 4'hA
`define DACWC_REG_ODCFG 4'hC
`define DACWC_REG_TSCFG 4'hD

// ****************************************
// General-purpose control and load mode fields
// ****************************************
`define DACWC_GP_PRECHARGE 9
`define DACWC_GP_BUF_EN 8
`define DACWC_GP_LOCK 7
`define DACWC_GP_BCAST 6
`define DACWC_GP_ADC_RANGE 5
`define DACWC_GP_DAC_RANGE 4
`define DACWC_LM_HI 1
`define DACWC_LM_LO 0

// ****************************************
// Load modes and pin functions
// ****************************************
`define DACWC_LM_IMMED 2'h0
`define DACWC_LM_HOLD 2'h1
`define DACWC_LM_ALL 2'h2
`define DACWC_PF_PULLDOWN 3'h0
`define DACWC_PF_ADC 3'h1
`define DACWC_PF_DAC 3'h2
`define DACWC_PF_DAC_ADC 3'h3
`define DACWC_PF_GPO 3'h4
`define DACWC_PF_GPI 3'h5
`define DACWC_PF_GPO_GPI 3'h6
`define DACWC_PF_TRISTATE 3'h7

// ****************************************
// Reset values
// ****************************************
`define DACWC_RST_BIT 1'h0
`define DACWC_RST_PINS 8'h00
`define DACWC_RST_PD_PINS 8'hFF
`define DACWC_RST_CODE 12'h000
`define DACWC_RST_LOADMODE 2'h0
`define DACWC_RST_PIN_SYNC 3'h3

`endif

// ---- dacwc_frame_rx.v ----
// Serial frame receiver: shifts on falling serial clock, ends on select high.
`timescale 1ns/10ps
module dacwc_frame_rx (
    input wire clk,
    input wire srst,
    input wire sync_n_lvl,
    input wire sclk_lvl,
    input wire sdi_lvl,
    output reg frame_ok_ff,
    output reg [15:0] frame_word_ff
);
`include "dacwc_defines.vh"

    reg sclk_prev_ff;
    reg sync_prev_ff;
    reg [15:0] shift_ff;
    reg [4:0] cnt_ff;
    wire sclk_fall;
    wire sync_rise;
    wire sync_fall;

    assign sclk_fall = sclk_prev_ff & ~sclk_lvl & ~sync_n_lvl;
    assign sync_rise = ~sync_prev_ff & sync_n_lvl;
    assign sync_fall = sync_prev_ff & ~sync_n_lvl;

    // ****************************************
    // Shift and execute
    // ****************************************
    always @(posedge clk) begin
        if (srst) begin
            sclk_prev_ff <= 1'h1;
            sync_prev_ff <= 1'h1;
            shift_ff <= 16'h0000;
            cnt_ff <= 5'h00;
            frame_ok_ff <= 1'h0;
            frame_word_ff <= 16'h0000;
        end else begin
            sclk_prev_ff <= sclk_lvl;
            sync_prev_ff <= sync_n_lvl;
            frame_ok_ff <= 1'h0;
            if (sync_fall) begin
                cnt_ff <= 5'h00;
            end else if (sclk_fall) begin
                shift_ff <= {shift_ff[14:0], sdi_lvl};
                if (cnt_ff != `DACWC_FRAME_CNT_OVER) begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
            end
            // Short or long frames are dropped rather than guessed at.
            if (sync_rise && cnt_ff == `DACWC_FRAME_CNT_FULL) begin
                frame_ok_ff <= 1'h1;
                frame_word_ff <= shift_ff;
            end
        end
    end

endmodule // dacwc_frame_rx

// ---- dacwc_host_model.sv ----
// Host serial controller model that sends command frames.
`timescale 1ns/10ps
module dacwc_host_model (
    input wire clk,
    output reg sync_n,
    output reg sclk,
    output reg sdi
);
    // ****************
    // Frame sender
    // ****************
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    // The serial clock idles high and only moves inside a frame.
    task automatic send(input [15:0] w, input integer n);
        integer i;
        begin
            @(posedge clk);
            sync_n <= 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                sdi <= w[15 - (i % 16)];
                repeat (4) @(posedge clk);
                sclk <= 1'b0;
                repeat (4) @(posedge clk);
                sclk <= 1'b1;
            end
            repeat (4) @(posedge clk);
            sync_n <= 1'b1;
            // A released data line must not keep showing the last bit.
            sdi <= ~sdi;
        end
    endtask
endmodule // dacwc_host_model

// ---- dacwc_pin_sync.v ----
// Three-stage synchroniser with agreement filter for the serial pins.
`timescale 1ns/10ps
module dacwc_pin_sync (
    input wire clk,
    input wire srst,
    input wire [2:0] pins_raw,
    output reg [2:0] pins_lvl_ff
);
`include "dacwc_defines.vh"

    reg [2:0] meta_ff;
    reg [2:0] sync2_ff;
    reg [2:0] sync3_ff;
    wire [2:0] nxt_pins_lvl;

    // ****************************************
    // Sampling chain
    // ****************************************
    // A level is taken over only once stages two and three agree.
    assign nxt_pins_lvl = (sync2_ff & sync3_ff) |
        (~(sync2_ff ^ sync3_ff) & sync2_ff) |
        ((sync2_ff ^ sync3_ff) & pins_lvl_ff);

    always @(posedge clk) begin
        if (srst) begin
            meta_ff <= `DACWC_RST_PIN_SYNC;
            sync2_ff <= `DACWC_RST_PIN_SYNC;
            sync3_ff <= `DACWC_RST_PIN_SYNC;
            pins_lvl_ff <= `DACWC_RST_PIN_SYNC;
        end else begin
            meta_ff <= pins_raw;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
            pins_lvl_ff <= nxt_pins_lvl;
        end
    end

endmodule // dacwc_pin_sync

// ---- dacwc_top.v ----
// DAC write decoding, pin configuration and general-purpose control.
//
// Behaviour
// - Frame executes when select rises after sixteen edges.
// - Last pin write wins; DAC, output stay primary.
// - Channel field codes 0..7 pick channels 0..7.
// - Control frame address 0011 writes general control.
// - Host writes zero into reserved bits.
// - Bit five selects ADC input range.
// - Bit four selects DAC output range.
// - Lock bit blocks pin configuration writes.
// - Buffer enable bit powers the ADC buffer.
// - Precharge powers buffer only during conversions.
// - Broadcast writes load every DAC-configured channel.
// - Top bit set means DAC input write.
// - Load mode alone moves input to DAC.
// - Mode 00 copies new data immediately.
// - Mode 01 holds data in input registers.
// - Mode 10 copies all channels at once.
// - After mode 10, revert to 01 if previous.
// - Address 0101 writes DAC pin configuration bits.
// - Set bit makes that pin a DAC output.
`timescale 1ns/10ps
module dacwc_top (
    input wire clk,
    input wire srst,
    input wire sync_n,
    input wire sclk,
    input wire sdi,
    input wire conversion_active,
    output wire [95:0] dac_code,
    output reg [95:0] input_code_ff,
    output reg [7:0] analog_output_select_bits_ff,
    output reg [23:0] pin_function_ff,
    output reg [7:0] open_drain_bits_ff,
    output reg [1:0] dac_load_mode_ff,
    output reg adc_range_double_ff,
    output reg dac_range_double_ff,
    output reg adc_buffer_enable_ff,
    output reg adc_buffer_precharge_ff,
    output reg adc_buffer_power_ff,
    output reg pin_config_locked_ff,
    output reg broadcast_write_ff,
    output reg command_done_ff
);
`include "dacwc_defines.vh"

    // ****************************************
    // Pin function resolution
    // ****************************************
    // Returns a pin's function after one configuration bit is written.
    function [2:0] dacwc_next_func;
        input [2:0] cur;
        input [3:0] reg_addr;
        input bit_val;
        reg is_dac;
        reg is_adc;
        reg is_gpo;
        reg is_gpi;
        begin
            is_dac = (cur == `DACWC_PF_DAC) || (cur == `DACWC_PF_DAC_ADC);
            is_adc = (cur == `DACWC_PF_ADC) || (cur == `DACWC_PF_DAC_ADC);
            is_gpo = (cur == `DACWC_PF_GPO) || (cur == `DACWC_PF_GPO_GPI);
            is_gpi = (cur == `DACWC_PF_GPI) || (cur == `DACWC_PF_GPO_GPI);
            dacwc_next_func = cur;
            case (reg_addr)
                `DACWC_REG_ADCCFG: begin
                    if (bit_val) begin
                        dacwc_next_func = is_dac ? `DACWC_PF_DAC_ADC :
                            `DACWC_PF_ADC;
                    end else if (cur == `DACWC_PF_ADC) begin
                        dacwc_next_func = `DACWC_PF_PULLDOWN;
                    end else if (cur == `DACWC_PF_DAC_ADC) begin
                        dacwc_next_func = `DACWC_PF_DAC;
                    end
                end
                `DACWC_REG_DACCFG: begin
                    if (bit_val) begin
                        dacwc_next_func = is_adc ? `DACWC_PF_DAC_ADC :
                            `DACWC_PF_DAC;
                    end else if (cur == `DACWC_PF_DAC) begin
                        dacwc_next_func = `DACWC_PF_PULLDOWN;
                    end else if (cur == `DACWC_PF_DAC_ADC) begin
                        dacwc_next_func = `DACWC_PF_ADC;
                    end
                end
                `DACWC_REG_GPOCFG: begin
                    if (bit_val) begin
                        dacwc_next_func = is_gpi ? `DACWC_PF_GPO_GPI :
                            `DACWC_PF_GPO;
                    end else if (cur == `DACWC_PF_GPO) begin
                        dacwc_next_func = `DACWC_PF_PULLDOWN;
                    end else if (cur == `DACWC_PF_GPO_GPI) begin
                        dacwc_next_func = `DACWC_PF_GPI;
                    end
                end
                `DACWC_REG_GPICFG: begin
                    if (bit_val) begin
                        dacwc_next_func = is_gpo ? `DACWC_PF_GPO_GPI :
                            `DACWC_PF_GPI;
                    end else if (cur == `DACWC_PF_GPI) begin
                        dacwc_next_func = `DACWC_PF_PULLDOWN;
                    end else if (cur == `DACWC_PF_GPO_GPI) begin
                        dacwc_next_func = `DACWC_PF_GPO;
                    end
                end
                `DACWC_REG_PDCFG: begin
                    if (bit_val) begin
                        dacwc_next_func = `DACWC_PF_PULLDOWN;
                    end
                end
                `DACWC_REG_TSCFG: begin
                    if (bit_val) begin
                        dacwc_next_func = `DACWC_PF_TRISTATE;
                    end else if (cur == `DACWC_PF_TRISTATE) begin
                        dacwc_next_func = `DACWC_PF_PULLDOWN;
                    end
                end
                default: begin
                    dacwc_next_func = cur;
                end
            endcase
        end
    endfunction

    // ****************************************
    // Pin sampling and frame reception
    // ****************************************
    wire [2:0] pins_lvl;
    wire frame_ok;
    wire [15:0] frame_word;

    dacwc_pin_sync u_pin_sync (
        .clk(clk),
        .srst(srst),
        .pins_raw({sdi, sclk, sync_n}),
        .pins_lvl_ff(pins_lvl)
    );

    dacwc_frame_rx u_frame_rx (
        .clk(clk),
        .srst(srst),
        .sync_n_lvl(pins_lvl[0]),
        .sclk_lvl(pins_lvl[1]),
        .sdi_lvl(pins_lvl[2]),
        .frame_ok_ff(frame_ok),
        .frame_word_ff(frame_word)
    );

    // ****************************************
    // Frame decoding
    // ****************************************
    wire is_dac_write;
    wire is_ctrl;
    wire [3:0] reg_addr;
    wire [2:0] chan;
    wire [11:0] data_code;
    wire [7:0] pin_bits;
    wire wr_gpctl;
    wire wr_loadmode;
    wire wr_pincfg;
    wire cfg_addr;
    wire [1:0] req_mode;
    wire [7:0] dac_pin_mask;
    wire [7:0] write_hit;
    wire load_all;
    reg [11:0] input_reg_ff [0:7];
    reg [11:0] dac_reg_ff [0:7];

    assign is_dac_write = frame_ok & frame_word[`DACWC_BIT_KIND];
    assign is_ctrl = frame_ok & ~frame_word[`DACWC_BIT_KIND];
    assign reg_addr = frame_word[`DACWC_ADDR_HI:`DACWC_ADDR_LO];
    assign chan = frame_word[`DACWC_CHAN_HI:`DACWC_CHAN_LO];
    assign data_code = frame_word[`DACWC_DATA_HI:`DACWC_DATA_LO];
    assign pin_bits = frame_word[`DACWC_PINS_HI:`DACWC_PINS_LO];
    assign wr_gpctl = is_ctrl && (reg_addr == `DACWC_REG_GPCTL);
    assign wr_loadmode = is_ctrl && (reg_addr == `DACWC_REG_LOADMODE);
    assign req_mode = frame_word[`DACWC_LM_HI:`DACWC_LM_LO];
    assign cfg_addr = (reg_addr == `DACWC_REG_ADCCFG) ||
        (reg_addr == `DACWC_REG_DACCFG) ||
        (reg_addr == `DACWC_REG_PDCFG) ||
        (reg_addr == `DACWC_REG_GPOCFG) ||
        (reg_addr == `DACWC_REG_GPICFG) ||
        (reg_addr == `DACWC_REG_ODCFG) ||
        (reg_addr == `DACWC_REG_TSCFG);
    // Reserved bits are simply not looked at.
    assign wr_pincfg = is_ctrl && cfg_addr && !pin_config_locked_ff;

    // A channel counts as a DAC while its resolved function drives it.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_mask
            assign dac_pin_mask[g] =
                (pin_function_ff[g*3+:3] == `DACWC_PF_DAC) ||
                (pin_function_ff[g*3+:3] == `DACWC_PF_DAC_ADC);
            assign dac_code[g*12+:12] = dac_reg_ff[g];
        end
    endgenerate

    assign write_hit = broadcast_write_ff ? dac_pin_mask :
        (8'h01 << chan);
    assign load_all = wr_loadmode && (req_mode == `DACWC_LM_ALL);

    // ****************************************
    // General-purpose control register
    // ****************************************
    always @(posedge clk) begin
        if (srst) begin
            adc_range_double_ff <= `DACWC_RST_BIT;
            dac_range_double_ff <= `DACWC_RST_BIT;
            adc_buffer_enable_ff <= `DACWC_RST_BIT;
            adc_buffer_precharge_ff <= `DACWC_RST_BIT;
            pin_config_locked_ff <= `DACWC_RST_BIT;
            broadcast_write_ff <= `DACWC_RST_BIT;
        end else if (wr_gpctl) begin
            adc_range_double_ff <= frame_word[`DACWC_GP_ADC_RANGE];
            dac_range_double_ff <= frame_word[`DACWC_GP_DAC_RANGE];
            adc_buffer_enable_ff <= frame_word[`DACWC_GP_BUF_EN];
            adc_buffer_precharge_ff <= frame_word[`DACWC_GP_PRECHARGE];
            pin_config_locked_ff <= frame_word[`DACWC_GP_LOCK];
            broadcast_write_ff <= frame_word[`DACWC_GP_BCAST];
        end
    end

    // ****************************************
    // ADC buffer power
    // ****************************************
    // With precharge the buffer rests between conversions to save current.
    wire nxt_adc_buffer_power;

    assign nxt_adc_buffer_power = adc_buffer_enable_ff &&
        (!adc_buffer_precharge_ff || conversion_active);

    always @(posedge clk) begin
        if (srst) begin
            adc_buffer_power_ff <= `DACWC_RST_BIT;
        end else begin
            adc_buffer_power_ff <= nxt_adc_buffer_power;
        end
    end

    // ****************************************
    // Pin configuration registers
    // ****************************************
    reg [7:0] adc_cfg_ff;
    reg [7:0] pd_cfg_ff;
    reg [7:0] gpo_cfg_ff;
    reg [7:0] gpi_cfg_ff;
    reg [7:0] ts_cfg_ff;
    integer p;

    always @(posedge clk) begin
        if (srst) begin
            analog_output_select_bits_ff <= `DACWC_RST_PINS;
            adc_cfg_ff <= `DACWC_RST_PINS;
            pd_cfg_ff <= `DACWC_RST_PD_PINS;
            gpo_cfg_ff <= `DACWC_RST_PINS;
            gpi_cfg_ff <= `DACWC_RST_PINS;
            ts_cfg_ff <= `DACWC_RST_PINS;
            open_drain_bits_ff <= `DACWC_RST_PINS;
            for (p = 0; p < 8; p = p + 1) begin
                pin_function_ff[p*3+:3] <= `DACWC_PF_PULLDOWN;
            end
        end else if (wr_pincfg) begin
            case (reg_addr)
                `DACWC_REG_DACCFG: begin
                    analog_output_select_bits_ff <= pin_bits;
                end
                `DACWC_REG_ADCCFG: begin
                    adc_cfg_ff <= pin_bits;
                end
                `DACWC_REG_PDCFG: begin
                    pd_cfg_ff <= pin_bits;
                end
                `DACWC_REG_GPOCFG: begin
                    gpo_cfg_ff <= pin_bits;
                end
                `DACWC_REG_GPICFG: begin
                    gpi_cfg_ff <= pin_bits;
                end
                `DACWC_REG_TSCFG: begin
                    ts_cfg_ff <= pin_bits;
                end
                `DACWC_REG_ODCFG: begin
                    open_drain_bits_ff <= pin_bits;
                end
                default: begin
                    open_drain_bits_ff <= open_drain_bits_ff;
                end
            endcase
            for (p = 0; p < 8; p = p + 1) begin
                pin_function_ff[p*3+:3] <= dacwc_next_func(
                    pin_function_ff[p*3+:3], reg_addr, pin_bits[p]);
            end
        end
    end

    // ****************************************
    // Load mode register
    // ****************************************
    always @(posedge clk) begin
        if (srst) begin
            dac_load_mode_ff <= `DACWC_RST_LOADMODE;
        end else if (wr_loadmode) begin
            case (req_mode)
                `DACWC_LM_IMMED: begin
                    dac_load_mode_ff <= `DACWC_LM_IMMED;
                end
                `DACWC_LM_HOLD: begin
                    dac_load_mode_ff <= `DACWC_LM_HOLD;
                end
                `DACWC_LM_ALL: begin
                    // The one-shot transfer never persists as a mode.
                    dac_load_mode_ff <= dac_load_mode_ff;
                end
                default: begin
                    dac_load_mode_ff <= dac_load_mode_ff;
                end
            endcase
        end
    end

    // ****************************************
    // Input and DAC registers
    // ****************************************
    integer c;

    always @(posedge clk) begin
        if (srst) begin
            for (c = 0; c < 8; c = c + 1) begin
                input_reg_ff[c] <= `DACWC_RST_CODE;
                dac_reg_ff[c] <= `DACWC_RST_CODE;
            end
        end else if (is_dac_write) begin
            for (c = 0; c < 8; c = c + 1) begin
                if (write_hit[c]) begin
                    input_reg_ff[c] <= data_code;
                    if (dac_load_mode_ff == `DACWC_LM_IMMED) begin
                        dac_reg_ff[c] <= data_code;
                    end
                end
            end
        end else if (load_all) begin
            for (c = 0; c < 8; c = c + 1) begin
                dac_reg_ff[c] <= input_reg_ff[c];
            end
        end
    end
    // Outside mode 00 and the one-shot, DAC registers keep their value.

    // ****************************************
    // Status outputs
    // ****************************************
    integer s;

    always @(posedge clk) begin
        if (srst) begin
            input_code_ff <= 96'h0;
            command_done_ff <= 1'h0;
        end else begin
            for (s = 0; s < 8; s = s + 1) begin
                input_code_ff[s*12+:12] <= input_reg_ff[s];
            end
            command_done_ff <= frame_ok;
        end
    end

endmodule // dacwc_top

// ---- tb.sv ----
// Self-checking bench for the converter write and control block.
`timescale 1ns/10ps
module tb;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg conv = 1'b0;
    wire sync_n, sclk, sdi, ar, dr, be, bp, bpw, lk, bc, done;
    wire [95:0] dac, inp;
    wire [7:0] sel, od;
    wire [23:0] pf;
    wire [1:0] lm;
    integer n_fail = 0, n_compared = 0, seed = 28, i, ch;
    reg [95:0] e_in, e_dac;
    reg [11:0] d;
    dacwc_host_model u_host (.clk(clk), .sync_n(sync_n), .sclk(sclk),
        .sdi(sdi));
    dacwc_top DUT (.clk(clk), .srst(srst), .sync_n(sync_n), .sclk(sclk),
        .sdi(sdi), .conversion_active(conv), .dac_code(dac),
        .input_code_ff(inp), .analog_output_select_bits_ff(sel),
        .pin_function_ff(pf), .open_drain_bits_ff(od),
        .dac_load_mode_ff(lm), .adc_range_double_ff(ar),
        .dac_range_double_ff(dr), .adc_buffer_enable_ff(be),
        .adc_buffer_precharge_ff(bp), .adc_buffer_power_ff(bpw),
        .pin_config_locked_ff(lk), .broadcast_write_ff(bc),
        .command_done_ff(done));
    always #25 clk = ~clk;
    // ****************
    // Helpers
    // ****************
    function [95:0] put(input [95:0] r, input [2:0] c, input [11:0] v);
        begin
            put = r;
            put[c * 12 +: 12] = v;
        end
    endfunction
    function [23:0] pfx(input [7:0] b);
        integer j;
        begin
            for (j = 0; j < 8; j = j + 1)
                pfx[3 * j +: 3] = b[j] ? 3'h2 : 3'h0;
        end
    endfunction
    task results;
        begin
            $display("compared=%0d failed=%0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [95:0] got, input [95:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // The gap after each frame also keeps select high between frames.
    task frame(input [15:0] w, input integer n, input exp_done);
        integer k;
        reg seen;
        begin
            seen = 1'b0;
            u_host.send(w, n);
            for (k = 0; k < 20; k = k + 1) begin
                @(posedge clk);
                #1;
                if (done === 1'b1)
                    seen = 1'b1;
            end
            chk(seen, exp_done);
            if (exp_done && !seen)
                results;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        #2000000;
        n_fail = n_fail + 1;
        results;
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({ar, dr, be, bp, bpw, lk, bc, done, lm, sel, od}, 0);
        chk(dac | inp, 0);
        chk(pf, 0);
        e_in = 0;
        for (i = 0; i < 8; i = i + 1) begin
            d = $random(seed);
            frame({1'b1, i[2:0], d}, 16, 1'b1);
            e_in = put(e_in, i[2:0], d);
            chk(dac, e_in);
        end
        e_dac = e_in;
        frame(16'h3801, 16, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            ch = $random(seed);
            d = $random(seed);
            frame({1'b1, ch[2:0], d}, 16, 1'b1);
            e_in = put(e_in, ch[2:0], d);
        end
        chk(dac, e_dac);
        chk(inp, e_in);
        frame(16'h3802, 16, 1'b1);
        chk(dac, e_in);
        chk(lm, 2'h1);
        frame(16'h28A5, 16, 1'b1);
        chk(pf, pfx(8'hA5));
        frame(16'h1840, 16, 1'b1);
        chk(bc, 1'b1);
        d = $random(seed);
        frame({4'h9, d}, 16, 1'b1);
        for (i = 0; i < 8; i = i + 1)
            if (i[0] ? i > 4 : i != 4 && i != 6)
                e_in = put(e_in, i[2:0], d);
        chk(inp, e_in);
        frame(16'h1880, 16, 1'b1);
        chk({lk, bc}, 2'h2);
        frame(16'h28FF, 16, 1'b1);
        chk(sel, 8'hA5);
        frame(16'h1800, 16, 1'b1);
        frame(16'h605A, 16, 1'b1);
        chk(od, 8'h5A);
        frame(16'h28FF, 15, 1'b0);
        frame(16'h28FF, 17, 1'b0);
        chk(sel, 8'hA5);
        frame(16'h2001, 16, 1'b1);
        chk(pf[2:0], 3'h3);
        frame(16'h1830, 16, 1'b1);
        chk({ar, dr}, 2'h3);
        frame(16'h1900, 16, 1'b1);
        chk({be, bpw}, 2'h3);
        frame(16'h1B00, 16, 1'b1);
        chk({be, bp}, 2'h3);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk);
            conv <= $random(seed);
            repeat (2) @(posedge clk);
            #1;
            chk(bpw, conv);
        end
        results;
    end
endmodule // tb
